// >>> pkg/ltcs_pkg.sv
// Constants, register map and state codes of the local time counter.
// Assumes a single counter clock of CLK_PERIOD_NS and a 32-bit bus.
package ltcs_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS         = 1000;
    localparam int US_CYC        = US_NS / CLK_PERIOD_NS;
    localparam int PULSE_US      = 1;
    localparam int WAIT_US       = 20;
    localparam int OCT_BITS      = 10;
    localparam int SEC_OCTETS    = 6;
    localparam int DATE_OCTETS   = 6;
    localparam int RSV_OCTETS    = 4;
    localparam int TOD_OCTETS    = SEC_OCTETS + DATE_OCTETS + RSV_OCTETS;
    localparam int SYNC_LAT      = 3;
    localparam logic [29:0] NS_PER_SEC = 30'h3B9ACA00;
    localparam logic [19:0] FS_PER_NS  = 20'hF4240;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_PERIOD = 8'h04;
    localparam logic [7:0] ADR_ERR    = 8'h08;
    localparam logic [7:0] ADR_DRIFT  = 8'h0C;
    localparam logic [7:0] ADR_LD_SH  = 8'h10;
    localparam logic [7:0] ADR_LD_SL  = 8'h14;
    localparam logic [7:0] ADR_LD_NS  = 8'h18;
    localparam logic [7:0] ADR_CP_SH  = 8'h1C;
    localparam logic [7:0] ADR_CP_SL  = 8'h20;
    localparam logic [7:0] ADR_CP_NS  = 8'h24;
    localparam logic [7:0] ADR_SER    = 8'h28;
    localparam logic [7:0] ADR_NOW_SL = 8'h2C;
    localparam logic [7:0] ADR_NOW_NS = 8'h30;
    localparam logic [7:0] ADR_STAT   = 8'h34;
    // ************************************************************
    // Field positions and codes
    // ************************************************************
    localparam int CTRL_LOAD  = 0;
    localparam int CTRL_SAVE  = 1;
    localparam int CTRL_OSREQ = 2;
    localparam int CTRL_OSDIR = 3;
    localparam int CTRL_CSEL  = 4;
    localparam int CTRL_HIACC = 6;
    localparam int ERR_DIR    = 31;
    localparam int DRIFT_CODE = 30;
    localparam int SER_ACLR   = 0;
    localparam int SER_IN     = 1;
    localparam int SER_OUT    = 2;
    localparam logic [1:0] DRIFT_ADD = 2'h1;
    localparam logic [1:0] DRIFT_SUB = 2'h2;
    // ************************************************************
    // Reset values and states
    // ************************************************************
    localparam logic [7:0] RST_PERIOD_NS = 8'h0A;
    localparam logic [1:0] RST_CLK_SEL   = 2'h0;
    typedef enum logic [1:0] {
        RX_HUNT = 2'b00, RX_GAP = 2'b01, RX_BIT = 2'b10, RX_DONE = 2'b11
    } ltcs_rx_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00, TX_PULSE = 2'b01, TX_WAIT = 2'b10, TX_OCT = 2'b11
    } ltcs_tx_t;
endpackage : ltcs_pkg

// >>> src/ltcs_top.sv
// Local time counter with strobe load/save and serial time of day.
// Assumes core_clk_i is the selected counter clock; the clock mux
// itself sits outside and is steered by counter_clock_select_o.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
module ltcs_top
    import ltcs_pkg::*;
#(
    parameter int LAT_CYC = SYNC_LAT
) (
    input  wire logic        core_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        load_save_i,
    output logic             second_pulse_output_o,
    output logic      [1:0]  counter_clock_select_o
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [2:0]  pin_sync;
        logic        ack;
        logic [31:0] rdat;
        logic        load_en;
        logic        save_en;
        logic        os_req;
        logic        os_dir;
        logic        hiacc;
        logic [1:0]  clk_sel;
        logic [7:0]  per_ns;
        logic [19:0] err_fs;
        logic        err_dir;
        logic [29:0] roll_ns;
        logic [1:0]  drift_code;
        logic [15:0] ld_sh;
        logic [31:0] ld_sl;
        logic [29:0] ld_ns;
        logic [15:0] cp_sh;
        logic [31:0] cp_sl;
        logic [29:0] cp_ns;
        logic        auto_clr;
        logic        ser_in;
        logic        ser_out;
        logic [47:0] sec;
        logic [29:0] ns;
        logic [19:0] acc_fs;
        logic [29:0] drift_ns;
        logic        drift_hit;
        ltcs_rx_t    rx_st;
        logic [11:0] rx_tmr;
        logic [3:0]  rx_bit;
        logic [3:0]  rx_oct;
        logic [7:0]  rx_sh;
        logic [47:0] rx_sec;
        logic [29:0] rx_el;
        ltcs_tx_t    tx_st;
        logic [11:0] tx_tmr;
        logic [4:0]  tx_us;
        logic [3:0]  tx_bit;
        logic [3:0]  tx_oct;
        logic [47:0] tx_sec;
        logic        second_pulse_output;
    } ltcs_state_t;

    localparam int A_PULSE = US_CYC * PULSE_US;

    ltcs_state_t        q;
    ltcs_state_t        d;
    logic               wr;
    logic [7:0]         adr;
    logic [31:0]        m;
    logic               line;
    logic               edge_up;
    logic               edge_dn;
    logic               us_tick;
    logic               ld_any;
    logic signed [11:0] a_err;
    logic signed [11:0] a_drift;
    logic signed [11:0] a_os;
    logic signed [11:0] inc;
    logic [20:0]        acc_sum;
    logic [30:0]        ns_sum;
    logic [30:0]        d_sum;
    logic [29:0]        lat;
    logic [7:0]         tx_byte;

    // Refuse latencies the compensation cannot represent
    if (LAT_CYC < 1 || LAT_CYC > 7) begin : g_chk
        $error("LAT_CYC out of range");
    end

    // Byte-lane merge for Wishbone writes
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Fold a nanosecond value back into one second
    function automatic logic [29:0] ns_wrap(input logic [30:0] v);
        if (v >= {1'b0, NS_PER_SEC}) begin
            return 30'(v - {1'b0, NS_PER_SEC});
        end
        return v[29:0];
    endfunction : ns_wrap

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        d       = q;
        adr     = {wb_adr_i[7:2], 2'b00};
        m       = 32'h0000_0000;
        line    = q.pin_sync[1];
        edge_up = q.pin_sync[1] & ~q.pin_sync[2];
        edge_dn = ~q.pin_sync[1] & q.pin_sync[2];
        ld_any  = 1'b0;
        lat     = 30'({22'h0, q.per_ns} * LAT_CYC);
        tx_byte = 8'h00;
        // Second and third flops feed the detector; the first never does
        d.pin_sync = {q.pin_sync[1:0], load_save_i};

        // Error accumulator, direction zero takes a nanosecond away
        acc_sum = {1'b0, q.acc_fs} + {1'b0, q.err_fs};
        a_err   = 12'sh000;
        d.acc_fs = acc_sum[19:0];
        if (acc_sum >= {1'b0, FS_PER_NS}) begin
            d.acc_fs = 20'(acc_sum - {1'b0, FS_PER_NS});
            a_err = q.err_dir ? 12'sh001 : -12'sh001;
        end
        // Drift correction on the step after rollover
        a_drift = 12'sh000;
        if (q.drift_hit && q.drift_code == DRIFT_ADD) begin
            a_drift = 12'sh001;
        end else if (q.drift_hit && q.drift_code == DRIFT_SUB) begin
            a_drift = -12'sh001;
        end
        // One-shot request is a self-clearing pulse
        a_os = 12'sh000;
        if (q.os_req) begin
            a_os = q.os_dir ? 12'sh001 : -12'sh001;
        end
        d.os_req = 1'b0;
        inc = $signed({4'h0, q.per_ns}) + a_err + a_drift + a_os;

        // Time step with second carry
        ns_sum = 31'({1'b0, q.ns}) + 31'(inc);
        d.ns   = ns_wrap(ns_sum);
        if (ns_sum >= {1'b0, NS_PER_SEC}) begin
            d.sec = q.sec + 48'h1;
        end
        // Drift counter follows the same sequence
        d_sum = 31'({1'b0, q.drift_ns}) + 31'(inc);
        d.drift_hit = 1'b0;
        d.drift_ns  = d_sum[29:0];
        if (q.roll_ns != 30'h0 && d_sum >= {1'b0, q.roll_ns}) begin
            d.drift_hit = 1'b1;
            d.drift_ns  = 30'h0;
        end

        // Strobe load; every enabled channel sees the same edge
        if (edge_up && q.load_en && !q.ser_in) begin
            ld_any = 1'b1;
            d.sec  = {q.ld_sh, q.ld_sl};
            d.ns   = q.hiacc ? ns_wrap({1'b0, q.ld_ns} + {1'b0, lat})
                             : q.ld_ns;
        end
        // Serial load: seconds of the pulse plus elapsed time
        if (q.rx_st == RX_DONE && q.load_en && q.ser_in) begin
            ld_any = 1'b1;
            d.sec  = q.rx_sec;
            d.ns   = ns_wrap({1'b0, q.rx_el});
        end
        // Save captures the value before this cycle's update
        if (edge_up && q.save_en) begin
            {d.cp_sh, d.cp_sl} = q.sec;
            d.cp_ns = q.ns;
            if (q.hiacc && q.ns >= lat) begin
                d.cp_ns = q.ns - lat;
            end else if (q.hiacc) begin
                d.cp_ns = 30'({1'b0, q.ns} + {1'b0, NS_PER_SEC} - {1'b0, lat});
                {d.cp_sh, d.cp_sl} = q.sec - 48'h1;
            end
            if (q.auto_clr) begin
                d.save_en = 1'b0;
            end
        end

        // ********************************************************
        // Serial receiver
        // ********************************************************
        if (q.rx_st != RX_HUNT) begin
            d.rx_el = q.rx_el + {22'h0, q.per_ns};
        end
        unique case (q.rx_st)
            RX_HUNT: begin
                // End of the pulse marks a frame; its rise was 1 us ago
                if (edge_dn && q.ser_in) begin
                    d.rx_st  = RX_GAP;
                    d.rx_el  = 30'(PULSE_US * US_NS);
                    d.rx_oct = 4'h0;
                end
            end
            RX_GAP: begin
                if (edge_up) begin
                    d.rx_st  = RX_BIT;
                    d.rx_bit = 4'h0;
                    d.rx_tmr = 12'(US_CYC / 2);
                end
            end
            RX_BIT: begin
                d.rx_tmr = q.rx_tmr - 12'h001;
                if (q.rx_tmr == 12'h000) begin
                    d.rx_tmr = 12'(US_CYC - 1);
                    d.rx_bit = q.rx_bit + 4'h1;
                    if (q.rx_bit == 4'h0 && !line) begin
                        d.rx_st = RX_HUNT;
                    end else if (q.rx_bit == 4'(OCT_BITS - 1)) begin
                        d.rx_st  = line ? RX_HUNT : RX_GAP;
                        d.rx_oct = q.rx_oct + 4'h1;
                        if (q.rx_oct < 4'(SEC_OCTETS)) begin
                            d.rx_sec = {q.rx_sec[39:0], q.rx_sh};
                        end
                        if (!line && q.rx_oct == 4'(TOD_OCTETS - 1)) begin
                            d.rx_st = RX_DONE;
                        end
                    end else if (q.rx_bit != 4'h0) begin
                        d.rx_sh = {line, q.rx_sh[7:1]};
                    end
                end
            end
            RX_DONE: begin
                d.rx_st = RX_HUNT;
            end
        endcase
        if (!q.ser_in) begin
            d.rx_st = RX_HUNT;
        end

        // ********************************************************
        // Pulse and serial transmitter
        // ********************************************************
        us_tick  = (q.tx_tmr == 12'h000);
        d.tx_tmr = us_tick ? 12'(US_CYC - 1) : q.tx_tmr - 12'h001;
        if (q.tx_oct < 4'(SEC_OCTETS)) begin
            tx_byte = q.tx_sec[8*(SEC_OCTETS-1-int'(q.tx_oct)) +: 8];
        end
        unique case (q.tx_st)
            TX_IDLE: begin
                d.second_pulse_output = q.ser_out & q.second_pulse_output;
            end
            TX_PULSE: begin
                if (us_tick) begin
                    d.second_pulse_output   = 1'b0;
                    d.tx_us = 5'h0;
                    d.tx_st = q.ser_out ? TX_WAIT : TX_IDLE;
                end
            end
            TX_WAIT: begin
                if (us_tick) begin
                    d.tx_us = q.tx_us + 5'h1;
                end
                if (us_tick && q.tx_us == 5'(WAIT_US - 1)) begin
                    d.tx_st  = TX_OCT;
                    d.tx_bit = 4'h0;
                    d.tx_oct = 4'h0;
                    d.second_pulse_output    = 1'b1;
                end
            end
            TX_OCT: begin
                if (us_tick) begin
                    d.tx_bit = q.tx_bit + 4'h1;
                    if (q.tx_bit == 4'(OCT_BITS - 2)) begin
                        d.second_pulse_output = 1'b0;
                    end else if (q.tx_bit == 4'(OCT_BITS - 1)) begin
                        d.tx_bit = 4'h0;
                        d.tx_oct = q.tx_oct + 4'h1;
                        d.second_pulse_output    = 1'b1;
                        if (q.tx_oct == 4'(TOD_OCTETS - 1)) begin
                            d.tx_st = TX_IDLE;
                        end
                    end else begin
                        d.second_pulse_output = tx_byte[q.tx_bit[2:0]];
                    end
                end
            end
        endcase
        // Second boundary starts a new frame with the new second
        if (ns_sum >= {1'b0, NS_PER_SEC} && !ld_any) begin
            d.tx_st  = TX_PULSE;
            d.tx_tmr = 12'(A_PULSE - 1);
            d.tx_sec = d.sec;
            d.second_pulse_output    = 1'b1;
        end

        // ********************************************************
        // Wishbone slave, one wait state, bus write beats auto-clear
        // ********************************************************
        d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
        wr    = d.ack & wb_we_i;
        unique case (adr)
            ADR_CTRL: begin
                m = 32'h0;
                m[CTRL_LOAD]  = q.load_en;
                m[CTRL_SAVE]  = q.save_en;
                m[CTRL_OSDIR] = q.os_dir;
                m[CTRL_CSEL +: 2] = q.clk_sel;
                m[CTRL_HIACC] = q.hiacc;
            end
            ADR_PERIOD: m = {24'h0, q.per_ns};
            ADR_ERR:    m = {q.err_dir, 11'h0, q.err_fs};
            ADR_DRIFT:  m = {q.drift_code, q.roll_ns};
            ADR_LD_SH:  m = {16'h0, q.ld_sh};
            ADR_LD_SL:  m = q.ld_sl;
            ADR_LD_NS:  m = {2'h0, q.ld_ns};
            ADR_CP_SH:  m = {16'h0, q.cp_sh};
            ADR_CP_SL:  m = q.cp_sl;
            ADR_CP_NS:  m = {2'h0, q.cp_ns};
            ADR_SER:    m = {29'h0, q.ser_out, q.ser_in, q.auto_clr};
            ADR_NOW_SL: m = q.sec[31:0];
            ADR_NOW_NS: m = {2'h0, q.ns};
            ADR_STAT:   m = {24'h0, q.tx_st, q.rx_st, q.rx_oct};
            default:    m = 32'h0;
        endcase
        d.rdat = d.ack ? m : q.rdat;
        m = merge(m, wb_dat_i, wb_sel_i);
        if (wr) begin
            unique case (adr)
                ADR_CTRL: begin
                    d.load_en = m[CTRL_LOAD];
                    d.save_en = m[CTRL_SAVE];
                    d.os_req  = m[CTRL_OSREQ];
                    d.os_dir  = m[CTRL_OSDIR];
                    d.clk_sel = m[CTRL_CSEL +: 2];
                    d.hiacc   = m[CTRL_HIACC];
                end
                ADR_PERIOD: d.per_ns = m[7:0];
                ADR_ERR: begin
                    d.err_fs  = m[19:0];
                    d.err_dir = m[ERR_DIR];
                end
                ADR_DRIFT: begin
                    d.roll_ns    = m[29:0];
                    d.drift_code = m[DRIFT_CODE +: 2];
                end
                ADR_LD_SH: d.ld_sh = m[15:0];
                ADR_LD_SL: d.ld_sl = m;
                ADR_LD_NS: d.ld_ns = m[29:0];
                ADR_SER: begin
                    d.auto_clr = m[SER_ACLR];
                    d.ser_in   = m[SER_IN];
                    d.ser_out  = m[SER_OUT];
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q        <= '0;
            q.per_ns <= RST_PERIOD_NS;
            q.clk_sel <= RST_CLK_SEL;
            q.rx_st  <= RX_HUNT;
            q.tx_st  <= TX_IDLE;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o               = q.rdat;
    assign wb_ack_o               = q.ack;
    assign second_pulse_output_o  = q.second_pulse_output;
    assign counter_clock_select_o = q.clk_sel;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_ack_single: assert property (q.ack |=> !q.ack)
        else $error("ack held two cycles");
    chk_load_copy: assert property (
        edge_up && q.load_en && !q.ser_in |=> q.sec == $past({q.ld_sh, q.ld_sl}))
        else $error("load did not copy seconds");
    chk_save_copy: assert property (
        edge_up && q.save_en |=> {q.cp_sh, q.cp_sl} == $past(q.sec)
                                 || $past(q.hiacc))
        else $error("save did not capture seconds");
    chk_auto_clear: assert property (
        edge_up && q.save_en && q.auto_clr && !wr |=> !q.save_en)
        else $error("save enable not cleared");
    chk_ns_range: assert property (q.ns < NS_PER_SEC)
        else $error("nanoseconds beyond one second");
    chk_ns_step: assert property (
        !ld_any && ns_sum < {1'b0, NS_PER_SEC}
        |=> 31'({1'b0, q.ns}) == $past(31'({1'b0, q.ns}) + 31'(inc)))
        else $error("counter step wrong");
    chk_oneshot: assert property (
        q.os_req && !q.os_dir && !q.drift_hit && a_err == 12'sh000
        |-> inc == $signed({4'h0, q.per_ns}) - 12'sh001)
        else $error("one-shot not applied");
    chk_pulse_len: assert property (
        $rose(q.second_pulse_output) && q.tx_st == TX_PULSE |-> ##A_PULSE !q.second_pulse_output)
        else $error("pulse length wrong");
    chk_wait_low: assert property (
        q.tx_st == TX_WAIT |-> !q.second_pulse_output)
        else $error("line high in waiting segment");
    chk_stop_bit: assert property (
        q.tx_st == TX_OCT && q.tx_bit == 4'(OCT_BITS - 1) |-> !q.second_pulse_output)
        else $error("stop bit not low");

    cov_par_load: cover property (edge_up && q.load_en && !q.ser_in);
    cov_save:     cover property (edge_up && q.save_en);
    cov_ser_load: cover property (q.rx_st == RX_DONE && q.load_en);
    cov_tx_frame: cover property (q.tx_st == TX_OCT ##1 q.tx_st == TX_IDLE);
    cov_drift:    cover property (q.drift_hit && q.drift_code == DRIFT_ADD);
endmodule : ltcs_top

// >>> test/ltcs_strobe_model.sv
// Far-side source of the load/save strobe pin: plain strobe or serial frame.
// Assumes the bench pulses fire_i or frame_i once the setup writes are done.
`timescale 1ns/1ns
module ltcs_strobe_model
    import ltcs_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        fire_i,
    input  wire logic        frame_i,
    input  wire logic [47:0] tod_sec_i,
    output logic             load_save_o
);
    localparam int LEAD_CYC  = US_CYC * (PULSE_US + WAIT_US);
    localparam int BODY_CYC  = US_CYC * OCT_BITS * TOD_OCTETS;
    localparam int FRAME_CYC = LEAD_CYC + BODY_CYC + 1;
    logic [3:0]  hold_reg = 4'h0;
    logic [14:0] pos_reg  = 15'h0;
    logic [7:0]  oct_val;
    logic        serial_time_of_day;
    int          t;
    int          s;
    int          bitn;
    // Frame position counter, parks on the idle segment after the last octet
    always_ff @(posedge core_clk_i) begin
        if (frame_i) begin
            pos_reg <= 15'h1;
        end else if (pos_reg != 15'h0 && pos_reg != 15'(FRAME_CYC)) begin
            pos_reg <= pos_reg + 15'h1;
        end
    end
    // Pulse, wait, 16 octets LSB first with start/stop, then idle high
    always_comb begin
        t       = int'(pos_reg) - 1;
        s       = t - LEAD_CYC;
        bitn    = 0;
        oct_val = 8'hA5;                  // Date octets carry junk on purpose
        if (s >= 0 && s / (US_CYC * OCT_BITS) < SEC_OCTETS) begin
            oct_val = tod_sec_i[8 * (SEC_OCTETS - 1 - s / (US_CYC * OCT_BITS)) +: 8];
        end else if (s / (US_CYC * OCT_BITS) >= SEC_OCTETS + DATE_OCTETS) begin
            oct_val = 8'h00;
        end
        if (pos_reg == 15'h0) begin
            serial_time_of_day = 1'b0;
        end else if (t < US_CYC * PULSE_US) begin
            serial_time_of_day = 1'b1;
        end else if (s < 0) begin
            serial_time_of_day = 1'b0;
        end else if (s >= BODY_CYC) begin
            serial_time_of_day = 1'b1;
        end else begin
            bitn = (s / US_CYC) % OCT_BITS;
            if (bitn == 0) begin
                serial_time_of_day = 1'b1;
            end else if (bitn == OCT_BITS - 1) begin
                serial_time_of_day = 1'b0;
            end else begin
                serial_time_of_day = oct_val[bitn - 1];
            end
        end
    end
    // Held ten cycles so the pin synchroniser cannot miss the edge
    always_ff @(posedge core_clk_i) begin
        if (fire_i) hold_reg <= 4'hA;
        else if (hold_reg != 4'h0) hold_reg <= hold_reg - 4'h1;
    end
    assign load_save_o = (hold_reg != 4'h0) | serial_time_of_day;
endmodule : ltcs_strobe_model

// >>> test/ltcs_top_tb.sv
// Bench for the time counter: Wishbone tasks plus strobe scenarios.
// Assumes the strobe model on the pin and the map of the package.
`timescale 1ns/1ns
module ltcs_top_tb;
    import ltcs_pkg::*;
    logic core_clk_i = 1'b0, arst_n_i = 1'b0, cyc = 1'b0, we = 1'b0, fire = 1'b0;
    logic frame = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, seen;
    logic        ack, second_pulse_output, pin;
    logic [1:0]  csel;
    int          err_count = 0, comparisons = 0;
    initial forever #5 core_clk_i = ~core_clk_i;
    ltcs_top ltcs_top_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .load_save_i(pin),
        .second_pulse_output_o(second_pulse_output), .counter_clock_select_o(csel));
    ltcs_strobe_model ltcs_strobe_model_inst (.core_clk_i(core_clk_i), .fire_i(fire),
        .frame_i(frame), .tod_sec_i(48'h0000_1357_9BDF), .load_save_o(pin));
    // Wait for the pulse pin to rise; the edge seen is one cycle after launch
    task automatic wait_pps();
        int n;
        n = 0;
        do @(posedge core_clk_i); while (second_pulse_output !== 1'b1 && ++n < 1000);
        if (n >= 1000) err_count++;
    endtask : wait_pps
    // Classic cycle held until ack is sampled high, then released
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge core_clk_i); while (ack !== 1'b1 && ++n < 50);
        if (n >= 50) err_count++;
        seen = rdat;
        cyc <= 1'b0;
    endtask : bus
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Strobe rise, then room for the synchroniser latency to pass
    task automatic pulse();
        @(posedge core_clk_i);
        fire <= 1'b1;
        @(posedge core_clk_i);
        fire <= 1'b0;
        repeat (20) @(posedge core_clk_i);
    endtask : pulse
    task automatic close_out();
        if (err_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    // Watchdog well beyond the roughly 21000 cycles the tests need
    initial begin
        #400000;
        err_count++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        bus(0, ADR_PERIOD, 32'h0);
        check("period", seen, {24'h0, RST_PERIOD_NS});
        bus(1, ADR_CTRL, 32'h20);
        check("clock select", {30'h0, csel}, 32'h2);
        bus(1, ADR_LD_SH, 32'h0);
        bus(1, ADR_LD_SL, 32'h1234);
        bus(1, ADR_LD_NS, 32'h0);
        bus(1, ADR_CTRL, 32'h1);
        pulse();
        bus(0, ADR_NOW_SL, 32'h0);
        check("loaded seconds", seen, 32'h1234);
        // Serial input enabled: a plain strobe must not load
        bus(1, ADR_LD_SL, 32'h55);
        bus(1, ADR_SER, 32'h2);
        pulse();
        bus(0, ADR_NOW_SL, 32'h0);
        check("no parallel load", seen, 32'h1234);
        bus(1, ADR_SER, 32'h1);
        bus(1, ADR_CTRL, 32'h2);
        pulse();
        bus(0, ADR_CP_SL, 32'h0);
        check("captured seconds", seen, 32'h1234);
        bus(0, ADR_CTRL, 32'h0);
        check("save auto clear", seen, 32'h0);
        bus(0, 8'h3C, 32'h0);
        check("unmapped read", seen, 32'h0);
        // Plain pulse at the second wrap, loaded 1 us before it
        bus(1, ADR_LD_NS, 32'h3B9AC618);
        bus(1, ADR_CTRL, 32'h1);
        pulse();
        wait_pps();
        repeat (49) @(posedge core_clk_i);
        check("pulse high", {31'h0, second_pulse_output}, 32'h1);
        repeat (100) @(posedge core_clk_i);
        check("pulse ended", {31'h0, second_pulse_output}, 32'h0);
        bus(0, ADR_NOW_SL, 32'h0);
        check("second carry", seen, 32'h56);
        // Serial output: top seconds octet 0x81 after the wrap
        bus(1, ADR_LD_SH, 32'h8100);
        bus(1, ADR_SER, 32'h4);
        pulse();
        wait_pps();
        repeat (49) @(posedge core_clk_i);
        check("tx pulse", {31'h0, second_pulse_output}, 32'h1);
        repeat (951) @(posedge core_clk_i);
        check("tx wait low", {31'h0, second_pulse_output}, 32'h0);
        repeat (1150) @(posedge core_clk_i);
        check("tx start bit", {31'h0, second_pulse_output}, 32'h1);
        repeat (100) @(posedge core_clk_i);
        check("tx data bit 0", {31'h0, second_pulse_output}, 32'h1);
        repeat (100) @(posedge core_clk_i);
        check("tx data bit 1", {31'h0, second_pulse_output}, 32'h0);
        // Serial input: one whole frame, then the seconds are applied
        bus(1, ADR_SER, 32'h2);
        @(posedge core_clk_i);
        frame <= 1'b1;
        @(posedge core_clk_i);
        frame <= 1'b0;
        repeat (18300) @(posedge core_clk_i);
        bus(0, ADR_NOW_SL, 32'h0);
        check("serial load", seen, 32'h13579BDF);
        close_out();
    end
endmodule : ltcs_top_tb
